// *** bench/canes_bus_node.sv ***
// Behavioural far-side node that turns bench commands into counter events.
`timescale 1ns/1ps
module canes_bus_node (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic fire,
  input wire logic [2:0] kind,
  output logic rx_err_evt,
  output logic rx_err_big_evt,
  output logic rx_ok_evt,
  output logic tx_err_evt,
  output logic tx_ok_evt,
  output logic bus_off_recover_evt
);
  logic [5:0] ev_r;

  // One registered pulse per command, so two events never arrive in the same cycle.
  always_ff @(posedge aclk) begin
    ev_r <= (aresetn && fire) ? (6'h01 << kind) : 6'h00;
  end

  // Pulse order follows the command codes used by the bench.
  assign {bus_off_recover_evt, tx_ok_evt, tx_err_evt} = ev_r[5:3];
  assign {rx_ok_evt, rx_err_big_evt, rx_err_evt} = ev_r[2:0];
endmodule : canes_bus_node

// *** bench/tb_top.sv ***
// Self-checking bench for the CAN error-state and FIFO-pending status block.
`timescale 1ns/1ps
module tb_top;
  import canes_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [REG_AW-1:0] s_axi_awaddr = '0;
  logic [REG_AW-1:0] s_axi_araddr = '0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, fire = 1'b0;
  logic [31:0] s_axi_wdata = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic rx_err_evt, rx_err_big_evt, rx_ok_evt, tx_err_evt, tx_ok_evt, bus_off_recover_evt;
  logic [2:0] kind = '0;
  logic [63:0] fifo_src = '0, fifo_en = '0, s, e;
  logic [15:0] p;
  logic [4:0] st = '0;
  logic [3:0] prevf = '0;
  logic prev_any = 1'b0;
  logic [4:0] wa[3] = '{OFF_ERR_COUNTS, OFF_FIFO_PEND, 5'h10};
  int hk[12] = '{4, 3, 4, 3, 4, 5, 1, 2, 0, 1, 2, 5};
  int hn[12] = '{1, 16, 1, 18, 2, 1, 16, 1, 8, 17, 1, 1};
  int errors = 0, compares = 0, cycles = 0, txc = 0, rxc = 0, k;
  integer seed = 32'h1605;

  canes_status_top dut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .rx_err_evt, .rx_err_big_evt, .rx_ok_evt, .tx_err_evt,
    .tx_ok_evt, .bus_off_recover_evt, .fifo_src, .fifo_en, .irq
  );
  canes_bus_node node (
    .aclk, .aresetn, .fire, .kind, .rx_err_evt, .rx_err_big_evt, .rx_ok_evt,
    .tx_err_evt, .tx_ok_evt, .bus_off_recover_evt
  );

  // Free-running 20 MHz clock.
  always #25 aclk = ~aclk;

  // Cuts a hang short; the whole run needs fewer than two thousand cycles.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Compares %0d, errors %0d", compares, errors);
    if (errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : test_done

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Address and data are offered together and each is dropped once taken.
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] stb);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= stb;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rdr(input logic [4:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rdr

  // Expected error-count word from the model counters.
  function automatic logic [31:0] exp_err();
    logic [31:0] w;
    w = '0;
    w[BUS_OFF_BIT] = txc >= 256;
    w[TX_PASS_BIT] = txc >= 128;
    w[RX_PASS_BIT] = rxc >= 128;
    w[TX_WARN_BIT] = txc >= 96 && txc < 128;
    w[RX_WARN_BIT] = rxc >= 96 && rxc < 128;
    w[ANY_WARN_BIT] = w[TX_WARN_BIT] | w[RX_WARN_BIT];
    w[15:8] = txc[7:0];
    w[7:0] = rxc[7:0];
    return w;
  endfunction : exp_err

  // Every register reads zero with an OKAY answer, the unmapped word with an error.
  task automatic reset_check();
    // Idle bus: all readies up, no answer pending, interrupt low.
    check("idle_after_reset", {26'h0, s_axi_awready, s_axi_wready, s_axi_arready,
                               s_axi_bvalid, s_axi_rvalid, irq}, 32'h0000_0038);
    for (int i = 0; i < 5; i++) begin
      rdr(5'(i * 4));
      check("reset_value", rd, 32'h0);
      check("rresp", {30'h0, rr}, {30'h0, (i == 4) ? RESP_SLVERR : RESP_OKAY});
    end
  endtask : reset_check

  // Fires n events of one kind, steps the model and reads the counts after each.
  task automatic ev(input int kk, input int n);
    logic [31:0] w;
    repeat (n) begin
      @(posedge aclk);
      kind <= kk[2:0];
      fire <= 1'b1;
      @(posedge aclk);
      fire <= 1'b0;
      case (kk)
        0: rxc = (rxc < 255) ? rxc + 1 : 255;
        1: rxc = (rxc > 247) ? 255 : rxc + 8;
        2: rxc = (rxc > 127) ? 120 : (rxc > 0) ? rxc - 1 : 0;
        3: txc = (txc > 248) ? 256 : txc + 8;
        4: txc = (txc > 0 && txc < 256) ? txc - 1 : txc;
        default: begin
          txc = 0;
          rxc = 0;
        end
      endcase
      w = exp_err();
      st[3:0] = st[3:0] | ({w[BUS_OFF_BIT], w[TX_PASS_BIT], w[RX_PASS_BIT], w[16]} & ~prevf);
      prevf = {w[BUS_OFF_BIT], w[TX_PASS_BIT], w[RX_PASS_BIT], w[16]};
      rdr(OFF_ERR_COUNTS);
      check("err_counts", rd, w);
    end
  endtask : ev

  // Main sequence: registers, counter corners, random traffic, interrupts, FIFOs.
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    reset_check();
    foreach (wa[i]) begin
      wr(wa[i], 32'hFFFF_FFFF, 4'hF);
      check("bresp", {30'h0, rr}, {30'h0, (i == 2) ? RESP_SLVERR : RESP_OKAY});
    end
    rdr(OFF_ERR_COUNTS);
    check("ro_counts", rd, 32'h0);
    wr(OFF_INT_MASK, 32'h1F, 4'h1);
    foreach (hk[i]) ev(hk[i], hn[i]);
    repeat (150) begin
      k = $unsigned($random(seed)) % 5;
      if (txc > 200) k = 5;
      ev(k, 1);
    end
    rdr(OFF_INT_STAT);
    check("int_status", rd, {27'h0, st});
    check("irq_on", {31'h0, irq}, {31'h0, |st});
    wr(OFF_INT_STAT, 32'h1F, 4'h1);
    st = '0;
    rdr(OFF_INT_STAT);
    check("int_cleared", rd, 32'h0);
    check("irq_off", {31'h0, irq}, 32'h0);
    ev(5, 1);
    ev(1, 12);
    wr(OFF_INT_MASK, 32'h0, 4'h1);
    repeat (2) @(posedge aclk);
    check("irq_masked", {31'h0, irq}, 32'h0);
    wr(OFF_INT_MASK, 32'h1F, 4'h0);
    rdr(OFF_INT_MASK);
    check("mask_no_strobe", rd, 32'h0);
    wr(OFF_INT_MASK, 32'h1F, 4'h1);
    repeat (2) @(posedge aclk);
    check("irq_unmasked", {31'h0, irq}, 32'h1);
    // First two settings are the all-sources and all-enables corners.
    for (int i = 0; i < 24; i++) begin
      s = (i < 2) ? '1 : {$random(seed), $random(seed)};
      e = (i == 0) ? '0 : (i == 1) ? '1 : {$random(seed), $random(seed)};
      for (int n = 0; n < 16; n++) p[n] = |(s[4*n +: 4] & e[4*n +: 4]);
      if (|p && !prev_any) st[INT_FIFO] = 1'b1;
      prev_any = |p;
      @(posedge aclk);
      fifo_src <= s;
      fifo_en <= e;
      repeat (3) @(posedge aclk);
      rdr(OFF_FIFO_PEND);
      check("fifo_pending", rd, {16'h0, p});
    end
    rdr(OFF_INT_STAT);
    check("int_status_fifo", rd, {27'h0, st});
    // Second reset in mid-run with live counters and pending FIFOs.
    @(posedge aclk);
    aresetn <= 1'b0;
    fifo_src <= '0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    reset_check();
    test_done();
  end
endmodule : tb_top

// *** logic/canes_err_ctr.sv ***
// Saturating fault-confinement error counter, used for both directions.
`timescale 1ns/1ps
module canes_err_ctr #(
  parameter int W = 8,
  parameter int SMALL = 1,
  parameter int BIG = 8,
  parameter logic [W-1:0] CAP = '1,
  parameter logic [W-1:0] HIGH_MARK = '1,
  parameter logic [W-1:0] REENTRY = '0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic inc_small,
  input wire logic inc_big,
  input wire logic dec,
  input wire logic clr,
  output logic [W-1:0] count
);
  logic [W-1:0] count_r;
  logic [W-1:0] count_nxt;
  logic [W:0] sum;

  // Clear beats increment beats decrement; sums saturate at the cap so they never wrap.
  always_comb begin
    sum = '0;
    count_nxt = count_r;
    if (clr) begin
      count_nxt = '0;
    end else if (inc_big || inc_small) begin
      sum = {1'b0, count_r} + (W+1)'(inc_big ? BIG : SMALL);
      count_nxt = (sum > {1'b0, CAP}) ? CAP : sum[W-1:0];
    end else if (dec) begin
      if (count_r > HIGH_MARK) begin
        count_nxt = REENTRY;
      end else if (count_r != '0) begin
        count_nxt = count_r - W'(1);
      end
    end
  end

  // Counter state clears on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_r <= '0;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign count = count_r;

  property p_clr_zero;
    @(posedge aclk) disable iff (!aresetn) clr |=> (count_r == '0);
  endproperty
  a_clr_zero: assert property (p_clr_zero) else $error("Counter did not clear.");

  property p_small_step;
    @(posedge aclk) disable iff (!aresetn)
      (inc_small && !inc_big && !clr && ({1'b0, count_r} + (W+1)'(SMALL) <= {1'b0, CAP}))
      |=> (count_r == $past(count_r) + W'(SMALL));
  endproperty
  a_small_step: assert property (p_small_step) else $error("Counter step wrong.");
endmodule : canes_err_ctr

// *** logic/canes_fifo_pend.sv ***
// Per-FIFO pending bits: OR of each FIFO's enabled interrupt sources.
`timescale 1ns/1ps
module canes_fifo_pend #(
  parameter int NUM_FIFO = 16,
  parameter int SRC_PER_FIFO = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [NUM_FIFO*SRC_PER_FIFO-1:0] fifo_src,
  input wire logic [NUM_FIFO*SRC_PER_FIFO-1:0] fifo_en,
  output logic [NUM_FIFO-1:0] fifo_pending_bits
);
  logic [NUM_FIFO-1:0] pend_r;
  logic [NUM_FIFO-1:0] pend_nxt;

  // Bit n follows FIFO n only; a disabled source never raises it.
  always_comb begin
    for (int n = 0; n < NUM_FIFO; n++) begin
      pend_nxt[n] = |(fifo_src[n*SRC_PER_FIFO +: SRC_PER_FIFO]
                    & fifo_en[n*SRC_PER_FIFO +: SRC_PER_FIFO]);
    end
  end

  // Registered so the bus read path sees a stable value.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pend_r <= '0;
    end else begin
      pend_r <= pend_nxt;
    end
  end

  assign fifo_pending_bits = pend_r;

  for (genvar g = 0; g < NUM_FIFO; g++) begin : g_chk
    property p_pend_follow;
      @(posedge aclk) disable iff (!aresetn)
        $past(aresetn) |-> (pend_r[g] == $past(|(fifo_src[g*SRC_PER_FIFO +: SRC_PER_FIFO]
          & fifo_en[g*SRC_PER_FIFO +: SRC_PER_FIFO])));
    endproperty
    a_pend_follow: assert property (p_pend_follow) else $error("Pending bit wrong.");
  end
endmodule : canes_fifo_pend

// *** logic/canes_pkg.sv ***
// Shared constants for the CAN error-state and FIFO-pending status block.
package canes_pkg;
  // Register word offsets on the AXI4-Lite port.
  localparam int REG_AW = 5;
  localparam logic [REG_AW-1:0] OFF_ERR_COUNTS = 5'h00;
  localparam logic [REG_AW-1:0] OFF_FIFO_PEND = 5'h04;
  localparam logic [REG_AW-1:0] OFF_INT_STAT = 5'h08;
  localparam logic [REG_AW-1:0] OFF_INT_MASK = 5'h0C;
  // Error-count register field positions.
  localparam int BUS_OFF_BIT = 21;
  localparam int TX_PASS_BIT = 20;
  localparam int RX_PASS_BIT = 19;
  localparam int TX_WARN_BIT = 18;
  localparam int RX_WARN_BIT = 17;
  localparam int ANY_WARN_BIT = 16;
  localparam int TX_CNT_LSB = 8;
  localparam int RX_CNT_LSB = 0;
  // Counter widths; the transmit side needs a ninth bit to reach bus-off.
  localparam int TX_CNT_W = 9;
  localparam int RX_CNT_W = 8;
  // Fault-confinement thresholds and counter steps.
  localparam logic [TX_CNT_W-1:0] BUS_OFF_LIMIT = 9'h100;
  localparam logic [TX_CNT_W-1:0] PASSIVE_LIMIT = 9'h080;
  localparam logic [TX_CNT_W-1:0] WARN_LIMIT = 9'h060;
  localparam logic [RX_CNT_W-1:0] RX_CAP = 8'hFF;
  localparam logic [RX_CNT_W-1:0] RX_REENTRY = 8'h78;
  localparam logic [RX_CNT_W-1:0] RX_HIGH_MARK = 8'h7F;
  localparam int SMALL_STEP = 1;
  localparam int BIG_STEP = 8;
  // Interrupt status bit positions; the mask register shares the layout.
  localparam int INT_W = 5;
  localparam int INT_WARN = 0;
  localparam int INT_RX_PASS = 1;
  localparam int INT_TX_PASS = 2;
  localparam int INT_BUS_OFF = 3;
  localparam int INT_FIFO = 4;
  localparam logic [INT_W-1:0] INT_RESET = 5'h00;
  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : canes_pkg

// *** logic/canes_status_top.sv ***
// CAN error-state and FIFO-pending status block with an AXI4-Lite register port.
`timescale 1ns/1ps
module canes_status_top
  import canes_pkg::*;
#(
  parameter int NUM_FIFO = 16,
  parameter int SRC_PER_FIFO = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [canes_pkg::REG_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [canes_pkg::REG_AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic rx_err_evt,
  input wire logic rx_err_big_evt,
  input wire logic rx_ok_evt,
  input wire logic tx_err_evt,
  input wire logic tx_ok_evt,
  input wire logic bus_off_recover_evt,
  input wire logic [NUM_FIFO*SRC_PER_FIFO-1:0] fifo_src,
  input wire logic [NUM_FIFO*SRC_PER_FIFO-1:0] fifo_en,
  output logic irq
);
  import canes_pkg::*;

  logic [TX_CNT_W-1:0] tx_cnt;
  logic [RX_CNT_W-1:0] rx_cnt;
  logic [NUM_FIFO-1:0] pend;
  logic bus_off_flag;
  logic tx_passive_flag;
  logic rx_passive_flag;
  logic tx_warning_flag;
  logic rx_warning_flag;
  logic any_warning_flag;
  logic [31:0] err_word;
  logic [31:0] fifo_word;

  // Transmit counter: a ninth bit lets it reach the bus-off count; it holds there.
  canes_err_ctr #(
    .W(TX_CNT_W), .SMALL(SMALL_STEP), .BIG(BIG_STEP), .CAP(BUS_OFF_LIMIT),
    .HIGH_MARK(BUS_OFF_LIMIT), .REENTRY(BUS_OFF_LIMIT)
  ) u_tx_ctr (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_small(1'b0),
    .inc_big(tx_err_evt),
    .dec(tx_ok_evt && !bus_off_flag),
    .clr(bus_off_recover_evt),
    .count(tx_cnt)
  );

  // Receive counter: a good frame above the passive line drops it back into range.
  canes_err_ctr #(
    .W(RX_CNT_W), .SMALL(SMALL_STEP), .BIG(BIG_STEP), .CAP(RX_CAP),
    .HIGH_MARK(RX_HIGH_MARK), .REENTRY(RX_REENTRY)
  ) u_rx_ctr (
    .aclk(aclk),
    .aresetn(aresetn),
    .inc_small(rx_err_evt),
    .inc_big(rx_err_big_evt),
    .dec(rx_ok_evt),
    .clr(bus_off_recover_evt),
    .count(rx_cnt)
  );

  canes_fifo_pend #(
    .NUM_FIFO(NUM_FIFO), .SRC_PER_FIFO(SRC_PER_FIFO)
  ) u_pend (
    .aclk(aclk),
    .aresetn(aresetn),
    .fifo_src(fifo_src),
    .fifo_en(fifo_en),
    .fifo_pending_bits(pend)
  );

  // Error-state flags decode straight from the counter registers.
  assign bus_off_flag = (tx_cnt >= BUS_OFF_LIMIT);
  assign tx_passive_flag = (tx_cnt >= PASSIVE_LIMIT);
  assign rx_passive_flag = ({1'b0, rx_cnt} >= PASSIVE_LIMIT);
  assign tx_warning_flag = (tx_cnt >= WARN_LIMIT) && (tx_cnt < PASSIVE_LIMIT);
  assign rx_warning_flag = ({1'b0, rx_cnt} >= WARN_LIMIT)
                           && ({1'b0, rx_cnt} < PASSIVE_LIMIT);
  assign any_warning_flag = tx_warning_flag || rx_warning_flag;

  // Read images; every unlisted bit stays zero.
  always_comb begin
    err_word = 32'h0000_0000;
    err_word[BUS_OFF_BIT] = bus_off_flag;
    err_word[TX_PASS_BIT] = tx_passive_flag;
    err_word[RX_PASS_BIT] = rx_passive_flag;
    err_word[TX_WARN_BIT] = tx_warning_flag;
    err_word[RX_WARN_BIT] = rx_warning_flag;
    err_word[ANY_WARN_BIT] = any_warning_flag;
    err_word[TX_CNT_LSB +: 8] = tx_cnt[7:0];
    err_word[RX_CNT_LSB +: 8] = rx_cnt;
    fifo_word = 32'h0000_0000;
    fifo_word[NUM_FIFO-1:0] = pend;
  end

  logic aw_hold_r;
  logic aw_hold_nxt;
  logic [REG_AW-1:0] aw_addr_r;
  logic [REG_AW-1:0] aw_addr_nxt;
  logic w_hold_r;
  logic w_hold_nxt;
  logic [31:0] wdata_r;
  logic [31:0] wdata_nxt;
  logic wstrb0_r;
  logic wstrb0_nxt;
  logic bvalid_r;
  logic bvalid_nxt;
  logic [1:0] bresp_r;
  logic [1:0] bresp_nxt;
  logic rvalid_r;
  logic rvalid_nxt;
  logic [1:0] rresp_r;
  logic [1:0] rresp_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic [INT_W-1:0] stat_r;
  logic [INT_W-1:0] stat_nxt;
  logic [INT_W-1:0] mask_r;
  logic [INT_W-1:0] mask_nxt;
  logic [INT_W-1:0] ev_prev_r;
  logic [INT_W-1:0] ev_now;
  logic aw_take;
  logic w_take;
  logic ar_take;
  logic do_write;
  logic [REG_AW-1:0] wa;
  logic [31:0] wd;
  logic ws0;

  // Address and data are accepted in either order and parked until both are in.
  assign s_axi_awready = !aw_hold_r && !bvalid_r;
  assign s_axi_wready = !w_hold_r && !bvalid_r;
  assign s_axi_arready = !rvalid_r;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign do_write = (aw_hold_r || aw_take) && (w_hold_r || w_take);
  assign wa = aw_hold_r ? aw_addr_r : s_axi_awaddr;
  assign wd = w_hold_r ? wdata_r : s_axi_wdata;
  assign ws0 = w_hold_r ? wstrb0_r : s_axi_wstrb[0];

  // Events are entries into a state, so a level that stays set raises one interrupt.
  assign ev_now = {(|pend), bus_off_flag, tx_passive_flag, rx_passive_flag, any_warning_flag};

  // Write channel, interrupt status and mask. A new event wins over a clearing write.
  always_comb begin
    aw_hold_nxt = aw_hold_r;
    aw_addr_nxt = aw_addr_r;
    w_hold_nxt = w_hold_r;
    wdata_nxt = wdata_r;
    wstrb0_nxt = wstrb0_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    mask_nxt = mask_r;
    stat_nxt = stat_r;
    if (aw_take) begin
      aw_hold_nxt = 1'b1;
      aw_addr_nxt = s_axi_awaddr;
    end
    if (w_take) begin
      w_hold_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
    end
    if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (do_write) begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      if (wa == OFF_INT_STAT && ws0) begin
        stat_nxt = stat_r & ~wd[INT_W-1:0];
      end else if (wa == OFF_INT_MASK && ws0) begin
        mask_nxt = wd[INT_W-1:0];
      end else if (wa != OFF_ERR_COUNTS && wa != OFF_FIFO_PEND
                   && wa != OFF_INT_STAT && wa != OFF_INT_MASK) begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    stat_nxt = stat_nxt | (ev_now & ~ev_prev_r);
  end

  // Read channel: data is captured at the address handshake.
  always_comb begin
    rvalid_nxt = rvalid_r;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    if (ar_take) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case (s_axi_araddr)
        OFF_ERR_COUNTS: rdata_nxt = err_word;
        OFF_FIFO_PEND: rdata_nxt = fifo_word;
        OFF_INT_STAT: rdata_nxt = {{(32-INT_W){1'b0}}, stat_r};
        OFF_INT_MASK: rdata_nxt = {{(32-INT_W){1'b0}}, mask_r};
        default: begin
          rdata_nxt = 32'h0000_0000;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
  end

  // Register stage for the bus and interrupt state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= '0;
      w_hold_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      rvalid_r <= 1'b0;
      rresp_r <= RESP_OKAY;
      rdata_r <= 32'h0000_0000;
      stat_r <= INT_RESET;
      mask_r <= INT_RESET;
      ev_prev_r <= INT_RESET;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      wdata_r <= wdata_nxt;
      wstrb0_r <= wstrb0_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
      ev_prev_r <= ev_now;
    end
  end

  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;
  assign irq = |(stat_r & mask_r);

  property p_bus_off;
    @(posedge aclk) disable iff (!aresetn) tx_cnt[8] |-> err_word[BUS_OFF_BIT] && err_word[20];
  endproperty
  a_bus_off: assert property (p_bus_off) else $error("Bus-off not shown.");

  property p_tx_pass;
    @(posedge aclk) disable iff (!aresetn) err_word[20] == (tx_cnt[8] || tx_cnt[7]);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("Tx passive wrong.");

  property p_rx_pass;
    @(posedge aclk) disable iff (!aresetn) err_word[19] == rx_cnt[7];
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("Rx passive wrong.");

  property p_tx_warn;
    @(posedge aclk) disable iff (!aresetn)
      err_word[18] == (tx_cnt[8:5] == 4'h3);
  endproperty
  a_tx_warn: assert property (p_tx_warn) else $error("Tx warning wrong.");

  property p_rx_warn;
    @(posedge aclk) disable iff (!aresetn) err_word[17] == (rx_cnt[7:5] == 3'h3);
  endproperty
  a_rx_warn: assert property (p_rx_warn) else $error("Rx warning wrong.");

  property p_any_warn;
    @(posedge aclk) disable iff (!aresetn) err_word[16] == (err_word[17] || err_word[18]);
  endproperty
  a_any_warn: assert property (p_any_warn) else $error("Combined warning wrong.");

  property p_tx_field;
    @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == OFF_ERR_COUNTS) |=> s_axi_rvalid
        && (s_axi_rdata[15:8] == $past(tx_cnt[7:0]));
  endproperty
  a_tx_field: assert property (p_tx_field) else $error("Tx count field wrong.");

  property p_rx_field;
    @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == OFF_ERR_COUNTS) |=> (s_axi_rdata[7:0] == $past(rx_cnt));
  endproperty
  a_rx_field: assert property (p_rx_field) else $error("Rx count field wrong.");

  property p_reserved;
    @(posedge aclk) disable iff (!aresetn)
      (ar_take && (s_axi_araddr == OFF_ERR_COUNTS || s_axi_araddr == OFF_FIFO_PEND))
      |=> (s_axi_rdata[31:22] == 10'h000)
        && ($past(s_axi_araddr) != OFF_FIFO_PEND || s_axi_rdata[31:16] == 16'h0000);
  endproperty
  a_reserved: assert property (p_reserved) else $error("Reserved bits not zero.");

  property p_pend_read;
    @(posedge aclk) disable iff (!aresetn)
      (ar_take && s_axi_araddr == OFF_FIFO_PEND) |=> (s_axi_rdata[15:0] == $past(pend));
  endproperty
  a_pend_read: assert property (p_pend_read) else $error("Pending read wrong.");
endmodule : canes_status_top
